// [rtl/pbc_pkg.sv]
// constants and types of the power and reset controller
package pbc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned LONG_PRESS_S     = 4;
    localparam int unsigned WDOG_S           = 4;
    localparam int unsigned RESET_TIMEOUT_MS = 20;
    localparam int unsigned RAIL_STEP_US     = 1000;
    localparam int unsigned CYCLE_OFF_MS     = 100;
    localparam int unsigned LONG_PRESS_CYC   = LONG_PRESS_S * CLK_HZ;
    localparam int unsigned WDOG_CYC         = WDOG_S * CLK_HZ;
    localparam int unsigned RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned RAIL_STEP_CYC    = RAIL_STEP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CYCLE_OFF_CYC    = CYCLE_OFF_MS * (CLK_HZ / 1000);
    localparam int          CNT_W            = 26;

    // ------------------------------------------------------------
    // rails: bit n-1 enables rail_n
    // ------------------------------------------------------------
    localparam int          RAIL_N      = 13;
    localparam logic [12:0] RAILS_ALL   = 13'h1fff;
    localparam logic [12:0] RAILS_SLEEP = 13'h1861;
    localparam logic [12:0] RAILS_SHUT  = 13'h1000;
    localparam logic [12:0] RAILS_NONE  = 13'h0000;
    localparam logic [3:0]  SEQ_LAST    = 4'hc;

    // ------------------------------------------------------------
    // register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFS_CONTROL = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_RAILS   = 8'h08;
    localparam int          CTL_WDOG    = 0;
    localparam int          CTL_IRQ_LO  = 1;
    localparam int          CTL_IRQ_HI  = 2;
    localparam int          ST_SOFT     = 0;
    localparam int          ST_CYCLE    = 1;
    localparam int          ST_STATE_LO = 2;
    localparam int          ST_STATE_HI = 3;
    localparam int          ST_KEEP13   = 4;
    localparam int          ST_RESET    = 5;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SYS_OFF,
        SYS_SEQ_UP,
        SYS_ON,
        SYS_CYCLE
    } pbc_sys_state_t;

    // power-up order, as rail bit indices
    localparam logic [3:0] SEQ_RAIL [13] = '{4'hc, 4'h5, 4'h3, 4'h1, 4'h2, 4'h4, 4'h6, 4'h0, 4'hb, 4'ha, 4'h9, 4'h7, 4'h8};

endpackage

// [rtl/pbc_sync.sv]
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module pbc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } pbc_sync_t;

    pbc_sync_t st;
    pbc_sync_t next_st;

    always_comb begin
        next_st        = st;
        next_st.stage1 = d;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.stage2;

endmodule

`default_nettype wire

// [rtl/pbc_power_reset_ctrl.sv]
// power modes, rail sequencing, push-button timing and reset control
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (R1) hold and enable high: all rails on
// (R2) sleep: rails 1,6,7,12,13 on
// (R3) shutdown: rail 13 only
// (R4) off with battery low: no rails
// (R5) rails rise 13,6,4,2,3,5,7,1,12,11,10,8,9
// (R6) resistor press enables, direct press resets
// (R7) short press: reset until release plus timeout
// (R8) soft reset flag, cleared by read
// (R9) long press: rails off, then on again
// (R10) power cycle flag, cleared by read
// (R11) processor pulses watchdog enable after soft reset
// (R12) button status low during a press
// (R13) reset low after startup until timeout
// (R14) interrupt low on unmasked pending flag
// (R15) interrupt sources reset masked
// (R16) enable press starts power-on
// (R17) processor raises hold before release
// (R18) release with hold low aborts start-up
// (R19) processor may delay hold or enable
// (R20) press or enable wakes sleep to all on
// (R21) watchdog expiry soft-resets
// (R22) timeouts are cycle-count parameters
// (R23) inputs synchronised before decoding
module pbc_power_reset_ctrl #(
    parameter int unsigned LONG_PRESS_CYC    = pbc_pkg::LONG_PRESS_CYC,
    parameter int unsigned WDOG_CYC          = pbc_pkg::WDOG_CYC,
    parameter int unsigned RESET_TIMEOUT_CYC = pbc_pkg::RESET_TIMEOUT_CYC,
    parameter int unsigned RAIL_STEP_CYC     = pbc_pkg::RAIL_STEP_CYC,
    parameter int unsigned CYCLE_OFF_CYC     = pbc_pkg::CYCLE_OFF_CYC
) (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    // axi4-lite write address
    input  wire logic [pbc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // axi4-lite read address
    input  wire logic [pbc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // mode and button pins
    input  wire logic                      powerHold,
    input  wire logic                      powerEnable,
    input  wire logic                      pushButtonInEnN,
    input  wire logic                      pushButtonInRstN,
    // battery comparators
    input  wire logic                      batteryAboveShutdown,
    input  wire logic                      batteryLow,
    // rail enables
    output logic [pbc_pkg::RAIL_N-1:0]     railEnable,
    // open-drain outputs
    output logic                           resetOut,
    output logic                           resetOutOeN,
    output logic                           interruptOut,
    output logic                           interruptOutOeN,
    output logic                           buttonStatusOut,
    output logic                           buttonStatusOeN
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pbc_pkg::pbc_sys_state_t      sysState;
        logic [3:0]                   seqStep;
        logic [pbc_pkg::CNT_W-1:0]    stepCnt;
        logic [12:0]                  rails;
        logic                         wake;
        logic                         cycleSeq;
        logic                         keep13;
        logic [pbc_pkg::CNT_W-1:0]    rstCnt;
        logic [pbc_pkg::CNT_W-1:0]    pressCnt;
        logic                         longDone;
        logic                         pressPrev;
        logic [pbc_pkg::CNT_W-1:0]    wdCnt;
        logic                         wdEnable;
        logic [1:0]                   irqEnable;
        logic                         srFlag;
        logic                         pcFlag;
        logic                         awready;
        logic                         wready;
        logic                         awHeld;
        logic                         wHeld;
        logic [pbc_pkg::ADDR_W-1:0]   awAddr;
        logic [31:0]                  wData;
        logic [3:0]                   wStrb;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         arready;
        logic                         rvalid;
        logic [31:0]                  rdata;
        logic [1:0]                   rresp;
        logic                         rstOeN;
        logic                         irqOeN;
        logic                         btnOeN;
        logic                         padLow;
    } pbc_state_t;

    pbc_state_t st;
    pbc_state_t next_st;

    localparam logic [pbc_pkg::CNT_W-1:0] LONG_LAST  = pbc_pkg::CNT_W'(LONG_PRESS_CYC - 1);
    localparam logic [pbc_pkg::CNT_W-1:0] WDOG_LAST  = pbc_pkg::CNT_W'(WDOG_CYC - 1);
    localparam logic [pbc_pkg::CNT_W-1:0] RST_DONE   = pbc_pkg::CNT_W'(RESET_TIMEOUT_CYC);
    localparam logic [pbc_pkg::CNT_W-1:0] STEP_LAST  = pbc_pkg::CNT_W'(RAIL_STEP_CYC - 1);
    localparam logic [pbc_pkg::CNT_W-1:0] CYCLE_LAST = pbc_pkg::CNT_W'(CYCLE_OFF_CYC - 1);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [5:0] syncIn;
    logic       hold;
    logic       enable;
    logic       pressEn;
    logic       pressRst;
    logic       batAbove;
    logic       batLow;

    pbc_sync #(
        .W (6)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       ({powerHold, powerEnable, ~pushButtonInEnN, ~pushButtonInRstN,
                   batteryAboveShutdown, batteryLow}),
        .q       (syncIn)
    ); // R23

    assign {hold, enable, pressEn, pressRst, batAbove, batLow} = syncIn;

    function automatic logic isReg(input logic [pbc_pkg::ADDR_W-1:0] a,
                                   input logic [pbc_pkg::ADDR_W-1:0] ofs);
        return {a[pbc_pkg::ADDR_W-1:2], 2'h0} == ofs;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic anyAccess;
    logic wdFire;
    logic cycleReq;
    logic softEvt;
    logic clrFlags;

    always_comb begin
        next_st   = st;
        anyAccess = (s_axi_awvalid && st.awready) || (s_axi_arvalid && st.arready);
        clrFlags  = s_axi_arvalid && st.arready && isReg(s_axi_araddr, pbc_pkg::OFS_STATUS);

        // watchdog, restarted by every bus access
        wdFire = st.wdEnable && !anyAccess && (st.wdCnt == WDOG_LAST); // R21
        if (!st.wdEnable || anyAccess || wdFire) begin
            next_st.wdCnt = '0;
        end else begin
            next_st.wdCnt = st.wdCnt + 1'b1;
        end

        // press duration timing
        cycleReq = pressRst && !st.longDone && (st.pressCnt == LONG_LAST); // R9
        if (pressRst) begin
            if (cycleReq) begin
                next_st.longDone = 1'b1;
            end else if (!st.longDone) begin
                next_st.pressCnt = st.pressCnt + 1'b1;
            end
        end else begin
            next_st.pressCnt = '0;
            next_st.longDone = 1'b0;
        end
        next_st.pressPrev = pressRst;
        softEvt = (st.pressPrev && !pressRst && !st.longDone) || wdFire; // R7 R21

        // status flags: a new event beats a clearing read
        next_st.srFlag = (st.srFlag && !clrFlags) || softEvt; // R8
        next_st.pcFlag = (st.pcFlag && !clrFlags) || cycleReq; // R10

        // rail 13 holds between the two battery thresholds
        if (batLow) begin
            next_st.keep13 = 1'b0; // R4
        end else if (batAbove) begin
            next_st.keep13 = 1'b1; // R3
        end

        // power state machine
        unique case (st.sysState)
            pbc_pkg::SYS_OFF: begin
                next_st.rails = st.keep13 ? pbc_pkg::RAILS_SHUT : pbc_pkg::RAILS_NONE; // R3 R4
                if (pressEn) begin
                    next_st.sysState = pbc_pkg::SYS_SEQ_UP; // R16
                    next_st.seqStep  = '0;
                    next_st.stepCnt  = '0;
                    next_st.cycleSeq = 1'b0;
                end
            end
            pbc_pkg::SYS_SEQ_UP: begin
                if (!st.cycleSeq && !pressEn && !hold) begin
                    next_st.sysState = pbc_pkg::SYS_OFF; // R18
                    next_st.rails    = pbc_pkg::RAILS_NONE;
                end else if (st.stepCnt == STEP_LAST) begin
                    next_st.stepCnt = '0;
                    next_st.rails   = st.rails | (13'h0001 << pbc_pkg::SEQ_RAIL[st.seqStep]); // R5
                    if (st.seqStep == pbc_pkg::SEQ_LAST) begin
                        next_st.sysState = pbc_pkg::SYS_ON;
                        next_st.wake     = 1'b0;
                    end else begin
                        next_st.seqStep = st.seqStep + 1'b1;
                    end
                end else begin
                    next_st.stepCnt = st.stepCnt + 1'b1;
                end
            end
            pbc_pkg::SYS_ON: begin
                if (!hold) begin
                    next_st.sysState = pbc_pkg::SYS_OFF;
                    next_st.rails    = st.keep13 ? pbc_pkg::RAILS_SHUT : pbc_pkg::RAILS_NONE;
                end else if (enable) begin
                    next_st.rails = pbc_pkg::RAILS_ALL; // R1
                    next_st.wake  = 1'b0;
                end else if (pressEn || st.wake) begin
                    next_st.rails = pbc_pkg::RAILS_ALL; // R20
                    next_st.wake  = 1'b1;
                end else begin
                    next_st.rails = pbc_pkg::RAILS_SLEEP; // R2
                end
            end
            pbc_pkg::SYS_CYCLE: begin
                next_st.rails = pbc_pkg::RAILS_NONE;
                if (st.stepCnt == CYCLE_LAST) begin
                    next_st.sysState = pbc_pkg::SYS_SEQ_UP; // R9
                    next_st.stepCnt  = '0;
                    next_st.seqStep  = '0;
                    next_st.cycleSeq = 1'b1;
                end else begin
                    next_st.stepCnt = st.stepCnt + 1'b1;
                end
            end
        endcase
        if (cycleReq) begin
            next_st.sysState = pbc_pkg::SYS_CYCLE; // R9
            next_st.rails    = pbc_pkg::RAILS_NONE;
            next_st.stepCnt  = '0;
        end

        // reset output: restart the timeout on any reset cause
        if (pressRst || softEvt || next_st.sysState == pbc_pkg::SYS_CYCLE
            || (next_st.sysState == pbc_pkg::SYS_SEQ_UP && next_st.cycleSeq)) begin
            next_st.rstCnt = '0; // R7
        end else if (st.rstCnt != RST_DONE) begin
            next_st.rstCnt = st.rstCnt + 1'b1; // R13 R22
        end
        next_st.rstOeN = (next_st.rstCnt == RST_DONE); // R7 R13

        // write: address and data in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.awAddr  = s_axi_awaddr;
            next_st.awready = 1'b0;
            next_st.awHeld  = 1'b1;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.wData  = s_axi_wdata;
            next_st.wStrb  = s_axi_wstrb;
            next_st.wready = 1'b0;
            next_st.wHeld  = 1'b1;
        end
        if (st.awHeld && st.wHeld) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = pbc_pkg::RESP_OKAY;
            if (isReg(st.awAddr, pbc_pkg::OFS_CONTROL)) begin
                if (st.wStrb[0]) begin
                    next_st.wdEnable  = st.wData[pbc_pkg::CTL_WDOG]; // R21
                    next_st.irqEnable = st.wData[pbc_pkg::CTL_IRQ_HI:pbc_pkg::CTL_IRQ_LO]; // R15
                end
            end else if (!isReg(st.awAddr, pbc_pkg::OFS_STATUS) && !isReg(st.awAddr, pbc_pkg::OFS_RAILS)) begin
                next_st.bresp = pbc_pkg::RESP_SLVERR;
            end
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end

        // read channel
        if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = pbc_pkg::RESP_OKAY;
            next_st.rdata   = '0;
            if (isReg(s_axi_araddr, pbc_pkg::OFS_CONTROL)) begin
                next_st.rdata[pbc_pkg::CTL_WDOG] = st.wdEnable;
                next_st.rdata[pbc_pkg::CTL_IRQ_HI:pbc_pkg::CTL_IRQ_LO] = st.irqEnable;
            end else if (isReg(s_axi_araddr, pbc_pkg::OFS_STATUS)) begin
                next_st.rdata[pbc_pkg::ST_SOFT]  = st.srFlag;
                next_st.rdata[pbc_pkg::ST_CYCLE] = st.pcFlag;
                next_st.rdata[pbc_pkg::ST_STATE_HI:pbc_pkg::ST_STATE_LO] = st.sysState;
                next_st.rdata[pbc_pkg::ST_KEEP13] = st.keep13;
                next_st.rdata[pbc_pkg::ST_RESET]  = !st.rstOeN;
            end else if (isReg(s_axi_araddr, pbc_pkg::OFS_RAILS)) begin
                next_st.rdata[pbc_pkg::RAIL_N-1:0] = st.rails;
            end else begin
                next_st.rresp = pbc_pkg::RESP_SLVERR;
            end
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end

        // open-drain pads
        next_st.irqOeN = !(|({next_st.pcFlag, next_st.srFlag} & next_st.irqEnable)); // R14
        next_st.btnOeN = !(pressEn || pressRst); // R6 R12
        next_st.padLow = 1'b0;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.sysState <= pbc_pkg::SYS_OFF;
            st.awready  <= 1'b1;
            st.wready   <= 1'b1;
            st.arready  <= 1'b1;
            st.rstOeN   <= 1'b0; // R13
            st.irqOeN   <= 1'b1;
            st.btnOeN   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready   = st.awready;
    assign s_axi_wready    = st.wready;
    assign s_axi_bresp     = st.bresp;
    assign s_axi_bvalid    = st.bvalid;
    assign s_axi_arready   = st.arready;
    assign s_axi_rdata     = st.rdata;
    assign s_axi_rresp     = st.rresp;
    assign s_axi_rvalid    = st.rvalid;
    assign railEnable      = st.rails;
    assign resetOut        = st.padLow;
    assign resetOutOeN     = st.rstOeN;
    assign interruptOut    = st.padLow;
    assign interruptOutOeN = st.irqOeN;
    assign buttonStatusOut = st.padLow;
    assign buttonStatusOeN = st.btnOeN;

endmodule

`default_nettype wire

// [test/pbc_checker.sv]
// pin-level assertions for the power and reset controller
`timescale 1ns/1ps
`default_nettype none
module pbc_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // levels in
    input wire logic        powerHold,
    input wire logic        powerEnable,
    input wire logic        pushButtonInEnN,
    input wire logic        pushButtonInRstN,
    input wire logic        batteryLow,
    // levels out
    input wire logic [12:0] railEnable,
    input wire logic        resetOut,
    input wire logic        resetOutOeN,
    input wire logic        interruptOut,
    input wire logic        buttonStatusOut,
    input wire logic        buttonStatusOeN
);
    // mid-sequence rail sets only
    wire mid = railEnable != 13'h0 && railEnable != pbc_pkg::RAILS_ALL
        && railEnable != pbc_pkg::RAILS_SLEEP && railEnable != pbc_pkg::RAILS_SHUT;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // two sync flops plus the output flop
    sequence press_s; !pushButtonInRstN[*4]; endsequence
    sequence free_s; (pushButtonInRstN && pushButtonInEnN)[*4]; endsequence
    pad_low_a: assert property ({resetOut, interruptOut, buttonStatusOut} == 3'h0)
        else $error("pad data high");
    press_status_a: assert property (press_s |-> !buttonStatusOeN)
        else $error("no status on press");
    free_status_a: assert property (free_s |-> buttonStatusOeN)
        else $error("status with no press");
    press_reset_a: assert property (press_s |-> !resetOutOeN)
        else $error("no reset on press");
    release_hold_a: assert property ($rose(pushButtonInRstN) |=> (!resetOutOeN)[*8])
        else $error("reset freed early");
    battery_off_a: assert property ((batteryLow && !powerHold && !powerEnable && pushButtonInEnN
        && pushButtonInRstN)[*8] |-> railEnable == 13'h0)
        else $error("rails on with battery low");
    rail_order_a: assert property ($changed(railEnable) && mid
        |-> railEnable == ($past(railEnable) | (13'h1 << pbc_pkg::SEQ_RAIL[$countones($past(railEnable))])))
        else $error("rail out of order");
    rail_gap_a: assert property ($changed(railEnable) && mid
        |=> ($stable(railEnable) || railEnable[11:0] == 12'h0)[*3])
        else $error("rail steps too close");
endmodule
bind pbc_power_reset_ctrl pbc_checker pbc_checker_i (.*);
`default_nettype wire

// [test/pbc_proc_model.sv]
// processor-side model driving the hold and enable levels
`timescale 1ns/1ps
`default_nettype none
module pbc_proc_model #(parameter int BOOT_CYC = 30) (
    // clock
    input  wire logic clk_sys,
    // bench commands
    input  wire logic bootReq,
    input  wire logic sleepReq,
    // mode levels
    output logic      powerHold,
    output logic      powerEnable
);
    int waitCnt = 0;
    // late hold makes a short press abort
    always @(posedge clk_sys) begin
        waitCnt <= bootReq ? waitCnt + 1 : 0;
        powerHold <= bootReq && waitCnt >= BOOT_CYC;
        powerEnable <= bootReq && waitCnt >= BOOT_CYC && !sleepReq;
    end
endmodule
`default_nettype wire

// [test/pbc_power_reset_ctrl_tb_top.sv]
// self-checking bench for the power and reset controller
`timescale 1ns/1ps
`default_nettype none
module pbc_power_reset_ctrl_tb_top;
    logic        clk_sys = 1'b0, rst_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        bootReq = 1'b0, sleepReq = 1'b0, powerHold, powerEnable, batteryLow = 1'b0;
    logic        pushButtonInEnN = 1'b1, pushButtonInRstN = 1'b1, batteryAboveShutdown = 1'b1;
    logic [12:0] railEnable;
    logic        resetOut, resetOutOeN, interruptOut, interruptOutOeN, buttonStatusOut, buttonStatusOeN;
    logic [31:0] d;
    logic [1:0]  r;
    int          n_mismatch = 0, n_checks = 0;
    pbc_power_reset_ctrl #(.LONG_PRESS_CYC(200), .WDOG_CYC(300), .RESET_TIMEOUT_CYC(50),
        .RAIL_STEP_CYC(4), .CYCLE_OFF_CYC(20)) pbc_power_reset_ctrl_i (.*);
    pbc_proc_model pbc_proc_model_i (.*);
    always #50 clk_sys = ~clk_sys;
    task automatic finish_test;
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic limit(input bit over);
        if (over) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (k = 0; k < 60; k++) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        limit(k == 60);
        check("bresp", s_axi_bresp, pbc_pkg::RESP_OKAY);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int k;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (k = 0; k < 60; k++) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        limit(k == 60);
    endtask
    task automatic s_startup;
        idle(2);
        check("reset held", resetOutOeN, 0);
        idle(60);
        check("reset freed", resetOutOeN, 1);
        check("shut rails", railEnable, pbc_pkg::RAILS_SHUT);
        axi_rd(pbc_pkg::OFS_CONTROL);
        check("masks", d, 0);
        axi_rd(8'h0c);
        check("unmapped", {d[1:0], r}, {2'h0, pbc_pkg::RESP_SLVERR});
    endtask
    task automatic s_soft;
        axi_wr(pbc_pkg::OFS_CONTROL, 32'h2);
        pushButtonInRstN <= 1'b0;
        idle(5);
        check("press reset", resetOutOeN, 0);
        idle(30);
        pushButtonInRstN <= 1'b1;
        idle(40);
        check("reset timeout", resetOutOeN, 0);
        idle(30);
        check("reset end", resetOutOeN, 1);
        check("irq soft", interruptOutOeN, 0);
        axi_rd(pbc_pkg::OFS_STATUS);
        check("soft flag", d[1:0], 2'h1);
        axi_rd(pbc_pkg::OFS_STATUS);
        check("soft clear", d[1:0], 2'h0);
        check("irq clear", interruptOutOeN, 1);
    endtask
    task automatic s_power_up;
        logic [12:0] prev;
        int k, n;
        pushButtonInEnN <= 1'b0;
        bootReq <= 1'b1;
        prev = railEnable;
        n = int'(prev[12]);
        for (k = 0; k < 300 && n < 13; k++) begin
            @(posedge clk_sys);
            if (railEnable !== prev) begin
                check("rail step", railEnable ^ prev, 32'h1 << pbc_pkg::SEQ_RAIL[n]);
                prev = railEnable;
                n++;
            end
        end
        limit(n < 13);
        pushButtonInEnN <= 1'b1;
        idle(8);
        check("all on", railEnable, pbc_pkg::RAILS_ALL);
        sleepReq <= 1'b1;
        idle(8);
        check("sleep", railEnable, pbc_pkg::RAILS_SLEEP);
        pushButtonInEnN <= 1'b0;
        idle(8);
        check("wake", railEnable, pbc_pkg::RAILS_ALL);
        check("status", buttonStatusOeN, 0);
        pushButtonInEnN <= 1'b1;
        sleepReq <= 1'b0;
        bootReq <= 1'b0;
        idle(8);
        check("shutdown", railEnable, pbc_pkg::RAILS_SHUT);
        {batteryLow, batteryAboveShutdown} <= 2'h2;
        idle(12);
        check("bat low", railEnable, 0);
        {batteryLow, batteryAboveShutdown} <= 2'h1;
    endtask
    task automatic s_abort;
        pushButtonInEnN <= 1'b0;
        idle(20);
        check("seq start", railEnable[5], 1);
        pushButtonInEnN <= 1'b1;
        idle(6);
        check("abort", railEnable[11:0], 0);
    endtask
    task automatic s_cycle;
        axi_wr(pbc_pkg::OFS_CONTROL, 32'h4);
        bootReq <= 1'b1;
        pushButtonInRstN <= 1'b0;
        idle(210);
        check("cycle off", railEnable, 0);
        pushButtonInRstN <= 1'b1;
        idle(120);
        check("cycle on", railEnable, pbc_pkg::RAILS_ALL);
        check("irq cycle", interruptOutOeN, 0);
        axi_rd(pbc_pkg::OFS_STATUS);
        check("cycle flag", d[1:0], 2'h2);
        axi_rd(pbc_pkg::OFS_STATUS);
        check("cycle clear", d[1:0], 2'h0);
    endtask
    initial begin
        idle(8);
        rst_n <= 1'b1;
        s_startup();
        s_soft();
        s_power_up();
        s_abort();
        s_cycle();
        axi_wr(pbc_pkg::OFS_CONTROL, 32'h1);
        idle(320);
        check("watchdog", resetOutOeN, 0);
        axi_wr(pbc_pkg::OFS_CONTROL, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
